// ---- shared/link_regs_pkg.sv ----
package link_regs_pkg;

  // ********************************
  // register map
  // ********************************
  localparam logic [11:0] LINK_CAP_OFFSET  = 12'h0CC;
  localparam logic [11:0] LINK_CTRL_OFFSET = 12'h0D0;
  localparam logic [11:0] LOAD_OFFSET      = 12'h0D8;
  localparam logic [11:0] LINK_OUT_OFFSET  = 12'h0DC;

  // ********************************
  // capability fields
  // ********************************
  localparam int SPEED_LSB   = 0;
  localparam int WIDTH_LSB   = 4;
  localparam int ASPMS_LSB   = 10;
  localparam int L0S_LSB     = 12;
  localparam int L1_LSB      = 15;
  localparam int CLKPM_BIT   = 18;
  localparam int SDOWN_BIT   = 19;
  localparam int DLACT_BIT   = 20;
  localparam int BWNOT_BIT   = 21;
  localparam int PORTNUM_LSB = 24;

  localparam logic [3:0] SPEED_2G5   = 4'h1;
  localparam logic [3:0] SPEED_5G0   = 4'h2;
  localparam logic [5:0] WIDTH_X4    = 6'h04;
  localparam logic [5:0] WIDTH_X1    = 6'h01;
  localparam logic [1:0] ASPMS_RST   = 2'h0;
  localparam logic [2:0] L0S_RST     = 3'h3;
  localparam logic [2:0] L1_RST      = 3'h0;

  // ********************************
  // control fields
  // ********************************
  localparam int ASPM_LSB    = 0;
  localparam int RCB_BIT     = 3;
  localparam int LDIS_BIT    = 4;
  localparam int RETRAIN_BIT = 5;
  localparam int CCLK_BIT    = 6;
  localparam int XSYNC_BIT   = 7;
  localparam int CLKPME_BIT  = 8;
  localparam int HAWD_BIT    = 9;
  localparam int BWMIE_BIT   = 10;
  localparam int ABWIE_BIT   = 11;

  localparam logic [1:0] ASPM_OFF  = 2'h0;
  localparam logic [1:0] ASPM_L0S  = 2'h1;
  localparam logic [1:0] ASPM_L1   = 2'h2;
  localparam logic [1:0] ASPM_BOTH = 2'h3;

  localparam int unsigned FTS_EXT  = 4096;
  localparam int unsigned TS1_EXT  = 1024;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0]  aspm_enable;
    logic        link_disable;
    logic        common_clock;
    logic        hw_width_disable;
    logic        bw_mgmt_int_en;
    logic        auto_bw_int_en;
    logic        l0s_entry_en;
    logic        l1_entry_en;
    logic        rx_l0s_allowed;
    logic [12:0] fts_count;
    logic [10:0] ts1_count;
    logic        clkreq_managed;
  } link_ctrl_t;

endpackage

// ---- src/link_cap_ctrl_regs.sv ----
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
// How it works
// - max speed field bits 3:0 encodes 2.5 as 1, 5.0 as 2, resets 2
// - max width resets x4 on upstream in four-lane mode, else x1
// - ASPM support field reports supported entry and resets to zero
// - L0s exit latency resets to code for 256 to under 512 ns
// - L1 exit latency resets to code zero, the shortest latency range
// - clock pm capability resets one upstream, hardwired zero downstream
// - DL active reporting zero upstream, resets one on downstream ports
// - bandwidth notification capability resets to zero on every port
// - port number field resets to the port's own index, zero to five
// - loadable capability defaults can be replaced by the autoload path
// - ASPM control resets zero; 01 L0s, 10 L1, 11 both, 00 none
// - receiver may always enter L0s whatever ASPM control says
// - read completion boundary bit always reads zero
// - link disable hardwired zero upstream, disables link downstream
// - retrain write starts retraining downstream, reads zero, upstream none
// - common clock bit resets zero, one means shared reference clock
// - extended synch sends 4096 FTS leaving L0s, 1024 TS1 leaving L1
// - clock pm enable zero holds clkreq low; hardwired zero downstream
// - bandwidth interrupt enables reset zero, read-only upstream
module link_cap_ctrl_regs
  import link_regs_pkg::*;
#(
  parameter int unsigned PORT_INDEX  = 0,
  parameter bit          UPSTREAM    = 1'b1,
  parameter bit          FOUR_LANE   = 1'b0
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // link layer side
  output link_ctrl_t       link_ctrl,
  output logic             retrain_pulse,
  output logic             clkreq_n_low_hold
);

  // ********************************
  // reset values per port
  // ********************************
  localparam bit    IS_DOWN   = !UPSTREAM;
  localparam logic [5:0] WIDTH_RST =
    (UPSTREAM && FOUR_LANE) ? WIDTH_X4 : WIDTH_X1;
  localparam logic [7:0] PORT_RST  = 8'(PORT_INDEX);

  // ********************************
  // axi write channel
  // ********************************
  logic        aw_held_reg;
  logic [11:0] aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        wr_go;

  // address and data are parked separately, so they may arrive in either
  // order; nothing new is taken until the response has been accepted,
  // which keeps one write in flight at the cost of some throughput
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign wr_go         = aw_held_reg && w_held_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_reg <= 1'b0;
    end
  end

  // unmapped words answer with an error and the write is dropped
  logic wr_hit;
  assign wr_hit = (aw_addr_reg[11:2] == LINK_CAP_OFFSET[11:2]) ||
                  (aw_addr_reg[11:2] == LINK_CTRL_OFFSET[11:2]) ||
                  (aw_addr_reg[11:2] == LOAD_OFFSET[11:2]) ||
                  (aw_addr_reg[11:2] == LINK_OUT_OFFSET[11:2]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // byte-lane merge of write data onto an old value
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic wr_cap;
  logic wr_ctrl;
  logic wr_load;
  logic [31:0] wr_merged_ctrl;
  assign wr_cap  = wr_go && (aw_addr_reg[11:2] == LINK_CAP_OFFSET[11:2]);
  assign wr_ctrl = wr_go && (aw_addr_reg[11:2] == LINK_CTRL_OFFSET[11:2]);
  assign wr_load = wr_go && (aw_addr_reg[11:2] == LOAD_OFFSET[11:2]);

  // ********************************
  // capability register
  // ********************************
  // the bus is blocked from writing here; the autoload path stages a
  // value in the load register and commits it with bit 0 of a write to this word
  logic [31:0] load_reg;
  logic [1:0]  aspms_reg;
  logic [2:0]  l0s_lat_reg;
  logic [2:0]  l1_lat_reg;
  logic        clkpm_cap_reg;
  logic        sdown_reg;
  logic        bwnot_reg;
  logic [7:0]  portnum_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_reg <= 32'h0000_0000;
    end else if (wr_load) begin
      load_reg <= merge(load_reg, w_data_reg, w_strb_reg);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aspms_reg     <= ASPMS_RST;
      l0s_lat_reg   <= L0S_RST;
      l1_lat_reg    <= L1_RST;
      clkpm_cap_reg <= UPSTREAM;
      sdown_reg     <= 1'b0;
      bwnot_reg     <= 1'b0;
      portnum_reg   <= PORT_RST;
    end else if (wr_cap && w_data_reg[0]) begin
      aspms_reg     <= load_reg[ASPMS_LSB +: 2];
      l0s_lat_reg   <= load_reg[L0S_LSB +: 3];
      l1_lat_reg    <= load_reg[L1_LSB +: 3];
      clkpm_cap_reg <= UPSTREAM && load_reg[CLKPM_BIT];
      sdown_reg     <= load_reg[SDOWN_BIT];
      bwnot_reg     <= load_reg[BWNOT_BIT];
      portnum_reg   <= load_reg[PORTNUM_LSB +: 8];
    end
  end

  logic [31:0] cap_word;
  always_comb begin
    cap_word = 32'h0000_0000;
    cap_word[SPEED_LSB +: 4]   = SPEED_5G0;
    cap_word[WIDTH_LSB +: 6]   = WIDTH_RST;
    cap_word[ASPMS_LSB +: 2]   = aspms_reg;
    cap_word[L0S_LSB +: 3]     = l0s_lat_reg;
    cap_word[L1_LSB +: 3]      = l1_lat_reg;
    cap_word[CLKPM_BIT]        = clkpm_cap_reg;
    cap_word[SDOWN_BIT]        = sdown_reg;
    cap_word[DLACT_BIT]        = IS_DOWN;
    cap_word[BWNOT_BIT]        = bwnot_reg;
    cap_word[PORTNUM_LSB +: 8] = portnum_reg;
  end

  // ********************************
  // control register
  // ********************************
  logic [1:0] aspm_reg;
  logic       ldis_reg;
  logic       cclk_reg;
  logic       xsync_reg;
  logic       clkpme_reg;
  logic       hawd_reg;
  logic       bwmie_reg;
  logic       abwie_reg;
  logic       retrain_reg;

  // port-type forcing is applied as the bit is stored, so what reads back
  // is already the value the link side acts on
  assign wr_merged_ctrl = merge(32'h0000_0000, w_data_reg, w_strb_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aspm_reg   <= ASPM_OFF;
      ldis_reg   <= 1'b0;
      cclk_reg   <= 1'b0;
      xsync_reg  <= 1'b0;
      clkpme_reg <= 1'b0;
      hawd_reg   <= 1'b0;
      bwmie_reg  <= 1'b0;
      abwie_reg  <= 1'b0;
    end else if (wr_ctrl) begin
      if (w_strb_reg[0]) begin
        aspm_reg  <= wr_merged_ctrl[ASPM_LSB +: 2];
        ldis_reg  <= IS_DOWN && wr_merged_ctrl[LDIS_BIT];
        cclk_reg  <= wr_merged_ctrl[CCLK_BIT];
        xsync_reg <= wr_merged_ctrl[XSYNC_BIT];
      end
      if (w_strb_reg[1]) begin
        clkpme_reg <= UPSTREAM && wr_merged_ctrl[CLKPME_BIT];
        hawd_reg   <= wr_merged_ctrl[HAWD_BIT];
        bwmie_reg  <= IS_DOWN ? wr_merged_ctrl[BWMIE_BIT] : 1'b0;
        abwie_reg  <= IS_DOWN ? wr_merged_ctrl[ABWIE_BIT] : 1'b0;
      end
    end
  end

  // retraining is a one-cycle request; the bit itself never reads back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      retrain_reg <= 1'b0;
    end else begin
      retrain_reg <= wr_ctrl && w_strb_reg[0] && IS_DOWN &&
                     wr_merged_ctrl[RETRAIN_BIT];
    end
  end
  assign retrain_pulse = retrain_reg;

  logic [31:0] ctrl_word;
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[ASPM_LSB +: 2] = aspm_reg;
    ctrl_word[RCB_BIT]       = 1'b0;
    ctrl_word[LDIS_BIT]      = ldis_reg;
    ctrl_word[RETRAIN_BIT]   = 1'b0;
    ctrl_word[CCLK_BIT]      = cclk_reg;
    ctrl_word[XSYNC_BIT]     = xsync_reg;
    ctrl_word[CLKPME_BIT]    = clkpme_reg;
    ctrl_word[HAWD_BIT]      = hawd_reg;
    ctrl_word[BWMIE_BIT]     = bwmie_reg;
    ctrl_word[ABWIE_BIT]     = abwie_reg;
  end

  // ********************************
  // link layer outputs
  // ********************************
  // registered so the link side sees glitch-free levels; they lag a
  // register write by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_ctrl         <= '0;
      clkreq_n_low_hold <= 1'b1;
    end else begin
      link_ctrl.aspm_enable      <= aspm_reg;
      link_ctrl.link_disable     <= ldis_reg;
      link_ctrl.common_clock     <= cclk_reg;
      link_ctrl.hw_width_disable <= hawd_reg;
      link_ctrl.bw_mgmt_int_en   <= bwmie_reg;
      link_ctrl.auto_bw_int_en   <= abwie_reg;
      link_ctrl.l0s_entry_en     <= aspm_reg[0];
      link_ctrl.l1_entry_en      <= aspm_reg[1];
      link_ctrl.rx_l0s_allowed   <= 1'b1;
      link_ctrl.fts_count  <= xsync_reg ? 13'(FTS_EXT) : 13'h0000;
      link_ctrl.ts1_count  <= xsync_reg ? 11'(TS1_EXT) : 11'h000;
      link_ctrl.clkreq_managed   <= clkpme_reg;
      clkreq_n_low_hold          <= !clkpme_reg;
    end
  end

  // ********************************
  // axi read channel
  // ********************************
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  // one read in flight: a new address waits while read data is pending
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      unique case (s_axi_araddr[11:2])
        LINK_CAP_OFFSET[11:2]:  rdata_reg <= cap_word;
        LINK_CTRL_OFFSET[11:2]: rdata_reg <= ctrl_word;
        LOAD_OFFSET[11:2]:      rdata_reg <= load_reg;
        LINK_OUT_OFFSET[11:2]:  rdata_reg <= {31'h0000_0000, ldis_reg};
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule

// ---- dv/link_regs_chk.sv ----
`timescale 1ns/1ns
module link_regs_chk
  import link_regs_pkg::*;
#(
  parameter bit UPSTREAM = 1'b1
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // link side
  input wire link_ctrl_t  link_ctrl,
  input wire logic        retrain_pulse,
  input wire logic        clkreq_n_low_hold
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // remembers which register the pending read points at
  logic [11:0] ar_addr;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ar_addr <= s_axi_araddr;
    end
  end

  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence

  property p_r_answer;
    s_ar_taken |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read late");
  property p_r_hold;
    s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("response moved");
  property p_cap;
    s_axi_rvalid && ar_addr == LINK_CAP_OFFSET |-> s_axi_rdata[3:0] ==
      SPEED_5G0 && s_axi_rdata[23:22] == 2'h0 &&
      s_axi_rdata[DLACT_BIT] == !UPSTREAM;
  endproperty
  a_cap: assert property (p_cap) else $error("capability bad");
  property p_ctrl;
    s_axi_rvalid && ar_addr == LINK_CTRL_OFFSET |->
      s_axi_rdata[31:12] == 20'h0 && s_axi_rdata[3:2] == 2'h0 &&
      !s_axi_rdata[RETRAIN_BIT];
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control bad");
  property p_slverr;
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_slverr: assert property (p_slverr) else $error("error data");
  property p_rx_l0s;
    $past(aresetn) |-> link_ctrl.rx_l0s_allowed;
  endproperty
  a_rx_l0s: assert property (p_rx_l0s) else $error("rx l0s off");
  property p_aspm;
    link_ctrl.l0s_entry_en == link_ctrl.aspm_enable[0] &&
      link_ctrl.l1_entry_en == link_ctrl.aspm_enable[1];
  endproperty
  a_aspm: assert property (p_aspm) else $error("aspm decode");
  property p_sync;
    link_ctrl.fts_count == (link_ctrl.ts1_count == 11'(TS1_EXT) ?
      13'(FTS_EXT) : 13'h0) &&
      (link_ctrl.ts1_count == 11'h0 || link_ctrl.ts1_count == 11'(TS1_EXT));
  endproperty
  a_sync: assert property (p_sync) else $error("synch counts");
  property p_clkreq;
    clkreq_n_low_hold == !link_ctrl.clkreq_managed &&
      (UPSTREAM || clkreq_n_low_hold);
  endproperty
  a_clkreq: assert property (p_clkreq) else $error("clkreq bad");
  property p_retrain;
    retrain_pulse |-> !UPSTREAM ##1 !retrain_pulse;
  endproperty
  a_retrain: assert property (p_retrain) else $error("retrain bad");
  property p_up_fixed;
    !(UPSTREAM && (link_ctrl.link_disable || link_ctrl.bw_mgmt_int_en ||
      link_ctrl.auto_bw_int_en));
  endproperty
  a_up_fixed: assert property (p_up_fixed) else $error("up bits");
endmodule

bind link_cap_ctrl_regs link_regs_chk #(.UPSTREAM(UPSTREAM)) chk (.*);

// ---- dv/link_side_model.sv ----
`timescale 1ns/1ns
module link_side_model
  import link_regs_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // from the register block
  input  wire link_ctrl_t link_ctrl,
  input  wire logic       retrain_pulse,
  // observed
  output logic [7:0]      retrain_count
);
  // the training logic acts once per pulse, so every pulse is counted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      retrain_count <= 8'h00;
    end else if (retrain_pulse) begin
      retrain_count <= retrain_count + 8'h01;
    end
  end
endmodule

// ---- dv/pcie_port_link_cap_ctrl_regs_tb.sv ----
`timescale 1ns/1ns
module pcie_port_link_cap_ctrl_regs_tb;
  import link_regs_pkg::*;
  logic        aclk;
  logic        aresetn;
  logic [11:0] s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  link_ctrl_t  link_ctrl;
  logic        retrain_pulse;
  logic        clkreq_n_low_hold;
  logic [7:0]  retrain_count;
  int          failures;
  int          num_checks;
  int          cycles;

  // downstream port, last index
  link_cap_ctrl_regs #(.PORT_INDEX(5), .UPSTREAM(1'b0), .FOUR_LANE(1'b0))
    dut (.*);
  link_side_model lsm (.*);

  always #50 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ****************
  // bus master
  // ****************
  // handshakes are taken at the rising edge, before any flop there moves
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic bh;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      bh = s_axi_bvalid;
      if (bh) chk({30'h0, s_axi_bresp}, {30'h0, er});
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic rh;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      rh = s_axi_rvalid;
      if (rh) chk(s_axi_rdata, ed);
      if (rh) chk({30'h0, s_axi_rresp}, {30'h0, er});
    end
    s_axi_rready <= 1'b0;
  endtask

  // control outputs: the ten flag bits at the top of the struct, aspm
  // first, then the synch counts, then the clkreq hold and managed pair
  task automatic lc_chk(input logic [9:0] e, input logic x);
    @(negedge aclk);
    chk({22'h0, link_ctrl[34:25]}, {22'h0, e});
    chk({8'h0, link_ctrl.fts_count, link_ctrl.ts1_count},
        x ? {8'h0, 13'(FTS_EXT), 11'(TS1_EXT)} : 32'h0);
    chk({30'h0, clkreq_n_low_hold, link_ctrl.clkreq_managed}, 32'h2);
  endtask

  task automatic complete_run();
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      complete_run();
    end
  end

  // ****************
  // tests
  // ****************
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb} = '0;
    {failures, num_checks, cycles} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(LINK_CAP_OFFSET, 32'h0510_3012, RESP_OKAY);
    rd(LINK_CTRL_OFFSET, 32'h0, RESP_OKAY);
    lc_chk(10'h001, 1'b0);
    wr(LINK_CTRL_OFFSET, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    lc_chk(10'h3FF, 1'b1);
    rd(LINK_CTRL_OFFSET, 32'h0000_0ED3, RESP_OKAY);
    rd(LINK_OUT_OFFSET, 32'h1, RESP_OKAY);
    chk({24'h0, retrain_count}, 32'h1);
    wr(LINK_CTRL_OFFSET, 32'h0, 4'h1, RESP_OKAY);
    rd(LINK_CTRL_OFFSET, 32'h0000_0E00, RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      wr(LINK_CTRL_OFFSET, 32'(c), 4'hF, RESP_OKAY);
      lc_chk({c[1:0], 5'h0, c[0], c[1], 1'b1}, 1'b0);
    end
    wr(LINK_CAP_OFFSET, 32'hFFFF_FFFE, 4'hF, RESP_OKAY);
    rd(LINK_CAP_OFFSET, 32'h0510_3012, RESP_OKAY);
    wr(12'h100, 32'h1, 4'hF, RESP_SLVERR);
    rd(12'h100, 32'h0, RESP_SLVERR);
    wr(LOAD_OFFSET, 32'h2A2F_5C00, 4'hF, RESP_OKAY);
    wr(LINK_CAP_OFFSET, 32'h1, 4'hF, RESP_OKAY);
    rd(LINK_CAP_OFFSET, 32'h2A3B_5C12, RESP_OKAY);
    chk({24'h0, retrain_count}, 32'h1);
    complete_run();
  end
endmodule
